// *** verilog/rsc_consts.vh ***
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// register offsets, both as printed; reg_select tells them apart
`define RSC_OFS_SUPPLY_MON 8'hff
`define RSC_OFS_RESET_CAUSE 8'hff
// reset cause and enable field positions
`define RSC_B_PIN 0
`define RSC_B_POR 1
`define RSC_B_MCD 2
`define RSC_B_WDT 3
`define RSC_B_SW 4
`define RSC_B_CMP 5
`define RSC_B_FLASH 6
`define RSC_B_USB 7
// supply monitor control field positions
`define RSC_B_SM_EN 7
`define RSC_B_SM_OK 6
// fixed values
`define RSC_RESET_VECTOR 16'h0000
`define RSC_PORT_LATCH_INIT 8'hff
`define RSC_FLASH_TOP 16'h3dff
`define RSC_WDT_DIV 4'd12
// synchroniser reset levels: cmp_out, vbus, missing, supply, pin
`define RSC_SYNC_INIT 5'b10001
// timing
`define RSC_CLK_NS 100
`define RSC_T_POR_NS 300000
`define RSC_T_RST_DLY_NS 5000
`define RSC_T_MCD_NS 100000
`define RSC_POR_CYC ((`RSC_T_POR_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_DLY_CYC ((`RSC_T_RST_DLY_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`endif

// *** verilog/rsc_reset_source_controller.v ***
// Summary of operation
// R01: power-up holds reset, pin low, then delay
// R02: power-on sets power-on flag on exit
// R03: any other reset except supply monitor clears power-on flag
// R04: every reset restarts at one fixed vector
// R05: supply monitor enable set by power-on and by software write
// R06: selected supply monitor low holds reset, pin
// R07: selecting unenabled supply monitor forces reset
// R08: software enables monitor, waits, then selects
// R09: monitor control: enable, live status, reserved
// R10: low reset pin resets, sets pin flag
// R11: enabled missing clock resets, sets flag
// R12: bit 2 write enables missing clock detector
// R13: comparator low output resets when selected
// R14: disabled comparator never causes a reset
// R15: watchdog enabled at clock/12, timeout resets
// R16: out-of-range flash access resets, sets flag
// R17: security-blocked flash access also resets
// R18: writing one to bit 4 forces reset
// R19: selected usb bus reset or vbus resets
// R20: internal resets other than supply monitor and forced power-on leave reset pin undriven
// R21: bit 1 selects supply monitor as source
// R22: read-modify-write reads stored enables, not flags
// R23: reset initialises registers, port latches ones
// R24: flags survive system reset, update at release
// R25: all requests merge into one stretched reset
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_reset_source_controller (
  input wire core_clk,
  input wire rst_n,
  input wire rst_pin_n_in,
  input wire supply_above_threshold_in,
  input wire missing_clock_in,
  input wire vbus_in,
  input wire comparator_out_in,
  input wire comparator_enabled,
  input wire watchdog_timeout,
  input wire watchdog_disable,
  input wire flash_write_req,
  input wire program_store_write_en,
  input wire code_space_read,
  input wire fetch_req,
  input wire [15:0] access_addr,
  input wire flash_security_block,
  input wire usb_bus_reset,
  input wire usb_enabled,
  input wire bus_supply_polarity,
  input wire reg_select,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire sfr_rmw,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  output reg sys_reset_n_q,
  output reg rst_pin_out_q,
  output reg rst_pin_oe_q,
  output reg [15:0] reset_vector_q,
  output reg [7:0] port_latch_q,
  output reg watchdog_enable_q,
  output reg watchdog_tick_q,
  output reg supply_monitor_enable_q
);

  // st_run: system free, requests sampled every cycle
  // st_hold: a level source still holds the system
  // st_stretch: counting the release delay
  // sequencer states
  localparam ST_RUN = 2'd0;
  localparam ST_HOLD = 2'd1;
  localparam ST_STRETCH = 2'd2;
  // delays in whole cycles, cut to the counter width on purpose;
  // both fit well inside 12 bits at this clock
  localparam [31:0] POR_CYC_W = `RSC_POR_CYC;
  localparam [31:0] DLY_CYC_W = `RSC_DLY_CYC;
  localparam [11:0] POR_CYC = POR_CYC_W[11:0];
  localparam [11:0] DLY_CYC = DLY_CYC_W[11:0];
  // reset level of every off-domain input, one bit per synchroniser
  localparam [4:0] SYNC_INIT = `RSC_SYNC_INIT;

  // three-stage synchronisers for off-domain inputs
  wire [4:0] async_in;
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] sync3_q;
  reg [4:0] filt_q; // accepted level once stages 2 and 3 agree

  // bit order matches sync_init: pin in bit 0, comparator in bit 4
  assign async_in = {comparator_out_in, vbus_in, missing_clock_in,
                     supply_above_threshold_in, rst_pin_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      // first stage only feeds the second
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[gi] <= SYNC_INIT[gi];
          sync2_q[gi] <= SYNC_INIT[gi];
          sync3_q[gi] <= SYNC_INIT[gi];
          filt_q[gi] <= SYNC_INIT[gi];
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          // glitch guard: a change counts only when two stages match
          if (sync2_q[gi] == sync3_q[gi]) begin
            filt_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire pin_n_f = filt_q[0];
  wire supply_ok_f = filt_q[1];
  wire missing_f = filt_q[2];
  wire vbus_f = filt_q[3];
  wire cmp_out_f = filt_q[4];

  // the pin is read back through its own synchroniser, so our own
  // drive would look like an external pin reset and lock the
  // sequencer in hold; ignore the pin while we drive it and for as
  // many cycles as the sync path needs after the drive stops
  reg [3:0] oe_hist_q; // recent history of our own pin drive
  wire pin_masked = rst_pin_oe_q || (oe_hist_q != 4'h0);
  wire pin_low = !pin_n_f && !pin_masked; // external pin reset seen

  // drive history, as deep as the pin synchroniser
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_hist_q <= 4'hf; // drive starts at power-on
    end else begin
      oe_hist_q <= {oe_hist_q[2:0], rst_pin_oe_q};
    end
  end

  // sequencer and stored state
  reg [1:0] state_q;
  reg [11:0] cnt_q;
  reg [7:0] cause_q; // cause being collected for this reset
  reg cause_por_q; // true power-on, not supply monitor
  reg [7:0] flags_q; // last-reset flags, kept across system reset
  reg sm_sel_q; // supply monitor selected as source
  reg mcd_en_q; // missing clock detector enabled
  reg cmp_sel_q; // comparator selected as source
  reg usb_sel_q; // usb selected as source
  reg [3:0] wdt_div_q; // divide-by-12 prescaler

  // both registers sit at one offset; reg_select picks which
  // register decode; writes ignored while the system is held
  wire running = (state_q == ST_RUN);
  wire wr_sm = running && sfr_wr && !reg_select && (sfr_addr == `RSC_OFS_SUPPLY_MON);
  wire wr_rc = running && sfr_wr && reg_select && (sfr_addr == `RSC_OFS_RESET_CAUSE);
  wire rd_sm = sfr_rd && !reg_select && (sfr_addr == `RSC_OFS_SUPPLY_MON);
  wire rd_rc = sfr_rd && reg_select && (sfr_addr == `RSC_OFS_RESET_CAUSE);

  // the three illegal-address checks share one comparator
  // out-of-range flash addresses
  wire addr_high = (access_addr > `RSC_FLASH_TOP);

  // requests only act in st_run; while a reset runs the event sources
  // are ignored until the release
  // request vector in flag layout
  reg [7:0] req;
  reg req_por; // forced power-on via pin flag write
  always @* begin
    req = 8'h00;
    req_por = wr_rc && sfr_wdata[`RSC_B_PIN];
    req[`RSC_B_PIN] = pin_low; // see R10
    // unenabled or low supply both trip a selected monitor
    req[`RSC_B_POR] = (sm_sel_q && (!supply_monitor_enable_q || !supply_ok_f)) // see R06
                      || (wr_rc && sfr_wdata[`RSC_B_POR] && !supply_monitor_enable_q) // see R07
                      || req_por;
    req[`RSC_B_MCD] = mcd_en_q && missing_f; // see R11
    req[`RSC_B_WDT] = watchdog_enable_q && watchdog_timeout; // see R15
    req[`RSC_B_SW] = wr_rc && sfr_wdata[`RSC_B_SW]; // see R18
    req[`RSC_B_CMP] = cmp_sel_q && comparator_enabled && !cmp_out_f; // see R13 see R14
    req[`RSC_B_FLASH] = (flash_write_req && program_store_write_en && addr_high)
                        || (code_space_read && addr_high)
                        || (fetch_req && addr_high); // see R16
    if (flash_security_block) begin
      req[`RSC_B_FLASH] = 1'b1; // see R17
    end
    req[`RSC_B_USB] = usb_sel_q && ((usb_bus_reset && usb_enabled)
                      || (vbus_f == bus_supply_polarity)); // see R19
  end

  // only pin and supply are levels; every other source is an event
  // that is remembered in cause_q and needs no hold
  // level sources keep the system held until they clear
  wire hold_cond = pin_low || (cause_q[`RSC_B_POR] && !supply_ok_f);
  wire [11:0] dly_target = cause_por_q ? POR_CYC : DLY_CYC;

  // one sequencer merges every source into one stretched reset
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // power applied: hold with pin driven, cause is power-on
      state_q <= ST_HOLD;
      cnt_q <= 12'h000;
      cause_q <= 8'h02;
      cause_por_q <= 1'b1;
      flags_q <= 8'h02;
      sm_sel_q <= 1'b0;
      mcd_en_q <= 1'b0;
      cmp_sel_q <= 1'b0;
      usb_sel_q <= 1'b0;
      supply_monitor_enable_q <= 1'b1;
      sys_reset_n_q <= 1'b0;
      rst_pin_oe_q <= 1'b1; // see R01
    end else begin
      case (state_q)
        ST_RUN: begin
          // source enables written by software
          if (wr_rc) begin
            usb_sel_q <= sfr_wdata[`RSC_B_USB];
            cmp_sel_q <= sfr_wdata[`RSC_B_CMP];
            mcd_en_q <= sfr_wdata[`RSC_B_MCD]; // see R12
            sm_sel_q <= sfr_wdata[`RSC_B_POR]; // see R21 see R08
          end
          if (wr_sm) begin
            supply_monitor_enable_q <= sfr_wdata[`RSC_B_SM_EN]; // see R09
          end
          // any request starts a system reset
          if (req != 8'h00) begin
            state_q <= ST_HOLD; // see R25
            cause_q <= req;
            cause_por_q <= req_por;
            sys_reset_n_q <= 1'b0;
            // only power-on and supply monitor drive the pin
            rst_pin_oe_q <= req[`RSC_B_POR]; // see R20
            // mcd, comparator and usb enables go back to defaults; supply monitor selection is kept
            mcd_en_q <= 1'b0; // see R23
            cmp_sel_q <= 1'b0;
            usb_sel_q <= 1'b0;
          end
        end
        ST_HOLD: begin
          // counter parked at zero while a source holds
          cnt_q <= 12'h000;
          if (!hold_cond) begin
            state_q <= ST_STRETCH;
          end
        end
        ST_STRETCH: begin
          if (hold_cond) begin
            state_q <= ST_HOLD; // source came back, start over
          end else if (cnt_q >= dly_target - 12'h001) begin
            // release: flags latch only now
            state_q <= ST_RUN;
            sys_reset_n_q <= 1'b1;
            rst_pin_oe_q <= 1'b0;
            if (cause_q[`RSC_B_POR]) begin
              flags_q <= 8'h02; // see R02
            end else begin
              flags_q <= cause_q; // see R03 see R24
            end
            if (cause_por_q) begin
              supply_monitor_enable_q <= 1'b1; // see R05
              sm_sel_q <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // port latches only change during reset here; the port logic
  // itself lives elsewhere and takes over after release
  // fixed outputs tied to the reset state
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_out_q <= 1'b0;
      reset_vector_q <= `RSC_RESET_VECTOR;
      port_latch_q <= `RSC_PORT_LATCH_INIT;
    end else begin
      rst_pin_out_q <= 1'b0; // open drain, only enable toggles
      reset_vector_q <= `RSC_RESET_VECTOR; // see R04
      if (!sys_reset_n_q) begin
        port_latch_q <= `RSC_PORT_LATCH_INIT; // see R23
      end
    end
  end

  // limitation: the divider restarts on every reset, so the first
  // tick after release comes a full twelve cycles later
  // watchdog enable and its clock/12 tick
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_enable_q <= 1'b1;
      watchdog_tick_q <= 1'b0;
      wdt_div_q <= 4'h0;
    end else begin
      watchdog_tick_q <= 1'b0;
      if (!sys_reset_n_q) begin
        watchdog_enable_q <= 1'b1; // see R15
        wdt_div_q <= 4'h0;
      end else begin
        // disable is one-way until the next reset
        if (watchdog_disable) begin
          watchdog_enable_q <= 1'b0;
        end
        if (wdt_div_q == `RSC_WDT_DIV - 4'd1) begin
          wdt_div_q <= 4'h0;
          watchdog_tick_q <= watchdog_enable_q;
        end else begin
          wdt_div_q <= wdt_div_q + 4'h1;
        end
      end
    end
  end

  // read data; rmw reads see enables so a write-back cannot
  // turn a flag into a new source selection
  reg [7:0] rc_view;
  always @* begin
    // plain reads show the cause flags of the last reset
    rc_view = flags_q;
    if (sfr_rmw) begin
      rc_view[`RSC_B_USB] = usb_sel_q; // see R22
      rc_view[`RSC_B_CMP] = cmp_sel_q;
      rc_view[`RSC_B_SW] = 1'b0; // never re-fires a software reset
      rc_view[`RSC_B_MCD] = mcd_en_q;
      rc_view[`RSC_B_POR] = sm_sel_q;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else begin
      // read data stands one cycle, zero otherwise
      if (rd_sm) begin
        // reserved bits read zero
        sfr_rdata_q <= {supply_monitor_enable_q, supply_ok_f, 6'h00}; // see R09
      end else if (rd_rc) begin
        sfr_rdata_q <= rc_view;
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end

endmodule

// *** tb/rsc_supply_model.sv ***
`timescale 1ns/10ps
module rsc_supply_model (
  input wire pin_oe,
  input wire pull_low,
  input wire supply_good,
  output wire pin_level,
  output wire supply_level
);
  // open-drain reset line with pull-up: low while either side pulls
  assign pin_level = !(pin_oe || pull_low);
  // monitor output follows the rail
  assign supply_level = supply_good;
endmodule

// *** tb/rsc_reset_source_controller_assertions.sv ***
`timescale 1ns/10ps
module rsc_checker (
  input wire core_clk,
  input wire rst_n,
  input wire reg_select,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire sys_reset_n_q,
  input wire rst_pin_oe_q,
  input wire [15:0] reset_vector_q,
  input wire [7:0] port_latch_q,
  input wire watchdog_enable_q,
  input wire watchdog_tick_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // software force while running
  sequence s_force;
    sys_reset_n_q && sfr_wr && reg_select && sfr_addr == 8'hff && sfr_wdata[4];
  endsequence
  sequence s_enter;
    $fell(sys_reset_n_q);
  endsequence
  a_sw_force: assert property (s_force |=> !sys_reset_n_q) else $error("no sw reset");
  a_min_stretch: assert property (s_enter |-> !sys_reset_n_q[*8]) else $error("short");
  a_pin_in_rst: assert property (rst_pin_oe_q |-> !sys_reset_n_q) else $error("pin");
  a_vector_zero: assert property (reset_vector_q == 16'h0000) else $error("vec");
  a_latch_ones: assert property ($rose(sys_reset_n_q) |-> port_latch_q == 8'hff)
    else $error("latch");
  a_wdt_on: assert property ($rose(sys_reset_n_q) |-> watchdog_enable_q) else $error("wdt");
  // cycles since the last watchdog tick; saturates, and a system
  // reset restarts the divider so the gap check starts over
  reg [3:0] since_tick_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_tick_q <= 4'hf;
    end else if (!sys_reset_n_q) begin
      since_tick_q <= 4'hf;
    end else if (watchdog_tick_q) begin
      since_tick_q <= 4'h0;
    end else if (since_tick_q != 4'hf) begin
      since_tick_q <= since_tick_q + 4'h1;
    end
  end
  a_tick_gap: assert property (watchdog_tick_q |-> since_tick_q >= 4'd11)
    else $error("tick");
  a_rd_idle: assert property (!$past(sfr_rd) |-> sfr_rdata_q == 8'h00) else $error("rd");
endmodule
bind rsc_reset_source_controller rsc_checker i_rsc_checker (.core_clk, .rst_n, .reg_select,
  .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q, .sys_reset_n_q, .rst_pin_oe_q,
  .reset_vector_q, .port_latch_q, .watchdog_enable_q, .watchdog_tick_q);

// *** tb/rsc_reset_source_controller_bench.sv ***
`timescale 1ns/10ps
module rsc_reset_source_controller_bench;
  reg core_clk = 0, rst_n = 0, pull_low = 0, supply_good = 1, vbus = 0, cmp_out = 1;
  reg cmp_en = 1, wdt_to = 0, wdt_dis = 0, fw = 0, psw = 0, cr = 0, fetch = 0, sec = 0;
  reg ubr = 0, uen = 1, sel = 1, wr = 0, rd = 0, rmw = 0, miss = 0, oe_seen = 0, pol = 1;
  reg [15:0] addr = 16'h3e00;
  reg [7:0] sa = 8'hff, wd = 8'h00, v;
  reg [15:0] rows [0:9];
  wire [7:0] rdata;
  wire sys_n, oe, pin, sup, wen, smen, pout;
  integer n_fail = 0, total_checks = 0, i;
  rsc_reset_source_controller i_rsc_reset_source_controller (.core_clk(core_clk),
    .rst_n(rst_n), .rst_pin_n_in(pin), .supply_above_threshold_in(sup),
    .missing_clock_in(miss), .vbus_in(vbus), .comparator_out_in(cmp_out),
    .comparator_enabled(cmp_en), .watchdog_timeout(wdt_to), .watchdog_disable(wdt_dis),
    .flash_write_req(fw), .program_store_write_en(psw), .code_space_read(cr),
    .fetch_req(fetch), .access_addr(addr), .flash_security_block(sec), .usb_bus_reset(ubr),
    .usb_enabled(uen), .bus_supply_polarity(pol), .reg_select(sel), .sfr_addr(sa),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rmw(rmw), .sfr_wdata(wd), .sfr_rdata_q(rdata),
    .sys_reset_n_q(sys_n), .rst_pin_out_q(pout), .rst_pin_oe_q(oe), .reset_vector_q(),
    .port_latch_q(), .watchdog_enable_q(wen), .watchdog_tick_q(),
    .supply_monitor_enable_q(smen));
  rsc_supply_model i_rsc_supply_model (.pin_oe(oe), .pull_low(pull_low),
    .supply_good(supply_good), .pin_level(pin), .supply_level(sup));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (oe) oe_seen = 1;
  task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick; begin @(posedge core_clk); #1; end endtask
  task swr(input s, input [7:0] d); begin tick; sel = s; wd = d; wr = 1; tick; wr = 0; end endtask
  task srd(input s, input m); begin tick; sel = s; rmw = m; rd = 1; tick; rd = 0; v = rdata; end
  endtask
  // wait into and out of a system reset, both bounded
  task cyc;
    integer k;
    begin
      for (k = 0; k < 20 && sys_n; k = k + 1) tick;
      for (k = 0; k < 5000 && !sys_n; k = k + 1) tick;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #2500000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    // enables written, flags expected; monitor is on before it is selected
    rows[0] = 16'h1210; rows[1] = 16'h0208; rows[2] = 16'h0240; rows[3] = 16'h0240;
    rows[4] = 16'h0240; rows[5] = 16'h0240; rows[6] = 16'h0604; rows[7] = 16'h2220;
    rows[8] = 16'h8280; rows[9] = 16'h8280;
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1;
    cyc;
    for (i = 0; i < 10; i = i + 1) begin
      swr(1, rows[i][15:8]);
      oe_seen = 0;
      case (i)
        1: wdt_to = 1;
        2: begin fw = 1; psw = 1; end
        3: cr = 1;
        4: fetch = 1;
        5: begin sec = 1; cr = 1; addr = 16'h0100; end
        6: miss = 1;
        7: cmp_out = 0;
        8: ubr = 1;
        9: vbus = 1;
        default: ;
      endcase
      tick;
      tick;
      {wdt_to, fw, psw, cr, fetch, sec, miss, ubr, vbus, cmp_out} = 10'h001;
      addr = 16'h3e00;
      cyc;
      srd(1, 0);
      check(v, rows[i][7:0], "flags");
      check(oe_seen, 0, "pin_oe");
    end
    check(smen, 1, "sm_en");
    wdt_dis = 1; tick; wdt_dis = 0; tick;
    swr(1, 8'h12); cyc;
    check(wen, 1, "wdt_on");
    cr = 1; addr = 16'h3dff; tick; tick; cr = 0;
    cmp_en = 0; swr(1, 8'h22); cmp_out = 0; repeat (10) tick;
    check(sys_n, 1, "no_rst");
    cmp_out = 1; repeat (5) tick; cmp_en = 1;
    pull_low = 1; repeat (10) tick; pull_low = 0; cyc; srd(1, 0);
    check(v, 8'h01, "pin_flag");
    supply_good = 0; repeat (10) tick;
    check({oe, sys_n}, 2'b10, "sm_hold");
    check(pout, 0, "pin_out");
    supply_good = 1; cyc; srd(1, 0);
    check(v, 8'h02, "sm_flag");
    swr(1, 8'h00); swr(0, 8'h00); swr(1, 8'h02); tick;
    check(sys_n, 0, "sel_rst");
    rst_n = 0; repeat (3) tick;
    check({oe, sys_n}, 2'b10, "por_pin");
    rst_n = 1; cyc; srd(1, 0);
    check(v, 8'h02, "por_flag");
    srd(0, 0); check(v, 8'hc0, "sm_ctrl");
    swr(0, 8'hff); srd(0, 0); check(v, 8'hc0, "sm_resv");
    swr(1, 8'ha6); srd(1, 1); check(v, 8'ha6, "rmw");
    srd(1, 0); check(v, 8'h02, "no_rmw");
    sa = 8'h12; srd(1, 0); check(v, 8'h00, "unmap");
    // usb still selected from the rmw write; flip the bus supply polarity
    sa = 8'hff;
    pol = 0;
    cyc;
    srd(1, 0);
    check(v, 8'h80, "vbus_pol");
    // bit 0 write forces a power-on style reset with the pin driven
    oe_seen = 0;
    swr(1, 8'h03);
    cyc;
    srd(1, 0);
    check(v, 8'h02, "sw_por");
    check(oe_seen, 1, "por_oe");
    conclude;
  end
endmodule
